/* File: hw/acof_cfg.svh */
// Register offsets, field positions, reset values, codes and timing counts
`ifndef ACOF_CFG_SVH
`define ACOF_CFG_SVH
// ==========================================
// Register offsets
`define ACOF_ADDR_PORT_CFG   8'h00
`define ACOF_ADDR_CLK_DIV    8'h72
`define ACOF_ADDR_FORMAT     8'h73
`define ACOF_ADDR_DLL        8'h74
`define ACOF_ADDR_POWER      8'h75
`define ACOF_ADDR_SYNC_ROLE  8'h77
`define ACOF_ADDR_CAL_STATUS 8'hB6
// ==========================================
// Fields and reset values
`define ACOF_SOFT_RESET_BIT  5
`define ACOF_PORT_CFG_RST    8'h00
`define ACOF_CLK_DIV_RST     8'h00
`define ACOF_FORMAT_RST      2'h1
`define ACOF_DLL_RST         1'h0
`define ACOF_POWER_RST       3'h0
`define ACOF_SYNC_ROLE_RST   1'h0
// ==========================================
// Codes
`define ACOF_FMT_OFFSET      2'h0
`define ACOF_FMT_TWOS        2'h1
`define ACOF_FMT_GRAY        2'h2
`define ACOF_STRAP_LOW       2'h0
`define ACOF_STRAP_FLOAT     2'h1
`define ACOF_STRAP_HIGH      2'h2
`define ACOF_PWR_NORMAL      2'h0
`define ACOF_PWR_NAP         2'h1
`define ACOF_PWR_SLEEP       2'h2
`define ACOF_DIV_PIN         2'h0
`define ACOF_DIV_1           2'h1
`define ACOF_DIV_2           2'h2
`define ACOF_DIV_4           2'h3
// ==========================================
// Timing
`define ACOF_CAL_CYCLES      64
`define ACOF_STRAP_SETTLE    2'h3
`endif

/* File: hw/acof_pkg.sv */
// Types shared by the converter control block
`default_nettype none
package acof_pkg;
  typedef enum logic [1:0] {CAL_HOLD, CAL_RUN, CAL_DONE} acof_cal_t;
endpackage
`default_nettype wire

/* File: hw/acof_sync2.sv */
// Two flip-flop synchroniser for pin inputs
`default_nettype none
module acof_sync2 #(
  parameter int             WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1_r <= RST_VAL;
      stage2_r <= RST_VAL;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
    end
  end

  assign pinSync = stage2_r;
endmodule // acof_sync2
`default_nettype wire

/* File: hw/acof_fmt.sv */
// Sample word encoder with over-range clamp
`default_nettype none
`include "acof_cfg.svh"
module acof_fmt (
  input  wire logic [15:0] offsetWord,
  input  wire logic [1:0]  format,
  input  wire logic        overHigh,
  input  wire logic        overLow,
  output logic      [15:0] outWord
);
  always_comb begin
    case (format)
      `ACOF_FMT_OFFSET: outWord = offsetWord;
      `ACOF_FMT_GRAY:   outWord = offsetWord ^ (offsetWord >> 1);
      default:          outWord = {~offsetWord[15], offsetWord[14:0]};
    endcase
    if (overHigh) begin
      outWord = 16'hFFFF;
    end else if (overLow) begin
      outWord = 16'h0000;
    end
  end
endmodule // acof_fmt
`default_nettype wire

/* File: hw/acof_top.sv */
// Converter control and output formatting top level
// What this block does
// - Low recalibration pin starts a new calibration
// - Over-range clamps output word to all ones high or all zeros low
// - Sample clock divider by two or four
// - Divider phase selects the sampling instant
// - Register divider ratio overrides strap pin
// - DLL slow or default fast range
// - Register 0x77 selects sync pair role
// - Sync pair defaults to link sync request
// - Sync input aligns lanes and devices
// - Soft-reset bit reruns reset and calibration
// - Soft-reset bit self-clears after calibration
// - Register power state overrides strap pin
// - Port disabled, but for 0xB6 reads, until strap saw normal
// - Format selectable, two's complement default
// - Offset binary spans zeros to ones
// - Two's complement inverts only the MSB
// - Calibration status bit at 0xB6 bit 0
// - Soft reset restores register defaults
// - Strap power state entered after calibration
`default_nettype none
`include "acof_cfg.svh"
module acof_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdData,
  input  wire logic        recal_request_n,
  input  wire logic [1:0]  divider_select_pin,
  input  wire logic [1:0]  power_state_pin,
  input  wire logic        sync_pair_pos,
  input  wire logic        sync_pair_neg,
  input  wire logic [15:0] coreSample,
  input  wire logic        coreValid,
  input  wire logic        coreOverHigh,
  input  wire logic        coreOverLow,
  output logic             sampleStrobe,
  output logic      [15:0] sampleWord,
  output logic             sampleValid,
  output logic             linkSyncRequestN,
  output logic             calRunning,
  output logic      [1:0]  powerState,
  output logic             dllRangeSlow
);
  // ==========================================
  // Pin synchronisers
  logic [6:0] pinSync;
  logic       recalN;
  logic [1:0] divStrap;
  logic [1:0] pwrStrap;
  logic       syncAsserted;

  // Reset value is the idle level of the recal and sync pins, so no false sync request follows reset
  acof_sync2 #(.WIDTH(7), .RST_VAL(7'h42)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinIn   ({recal_request_n, divider_select_pin, power_state_pin,
                sync_pair_pos, sync_pair_neg}),
    .pinSync (pinSync)
  );

  assign recalN       = pinSync[6];
  assign divStrap     = pinSync[5:4];
  assign pwrStrap     = pinSync[3:2];
  assign syncAsserted = ~pinSync[1] & pinSync[0];

  // ==========================================
  // Register file
  logic [7:0] portCfg_r, portCfg_nxt;
  logic [7:0] divider_select_pin_r, divider_select_pin_nxt;
  logic [1:0] format_r, format_nxt;
  logic       dll_r, dll_nxt;
  logic [2:0] power_r, power_nxt;
  logic       syncRole_r, syncRole_nxt;
  logic       softReset_r, softReset_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic       spiEnabled_r, spiEnabled_nxt;
  logic [1:0] settle_r, settle_nxt;
  logic       wrOk;
  logic       softWr;
  logic       calFinish;
  logic       calDone;

  assign wrOk   = regWr & spiEnabled_r;
  assign softWr = wrOk & (regAddr == `ACOF_ADDR_PORT_CFG)
                  & regWrData[`ACOF_SOFT_RESET_BIT];

  always_comb begin
    portCfg_nxt    = portCfg_r;
    divider_select_pin_nxt     = divider_select_pin_r;
    format_nxt     = format_r;
    dll_nxt        = dll_r;
    power_nxt      = power_r;
    syncRole_nxt   = syncRole_r;
    softReset_nxt  = softReset_r;
    spiEnabled_nxt = spiEnabled_r;
    settle_nxt     = settle_r;
    if (settle_r != `ACOF_STRAP_SETTLE) begin
      settle_nxt = settle_r + 2'h1;
    end else if (pwrStrap == `ACOF_STRAP_LOW) begin
      spiEnabled_nxt = 1'b1;
    end
    if (calFinish) begin
      softReset_nxt = 1'b0;
    end
    if (softWr) begin
      portCfg_nxt   = `ACOF_PORT_CFG_RST;
      divider_select_pin_nxt    = `ACOF_CLK_DIV_RST;
      format_nxt    = `ACOF_FORMAT_RST;
      dll_nxt       = `ACOF_DLL_RST;
      power_nxt     = `ACOF_POWER_RST;
      syncRole_nxt  = `ACOF_SYNC_ROLE_RST;
      softReset_nxt = 1'b1;
    end else if (wrOk) begin
      case (regAddr)
        `ACOF_ADDR_PORT_CFG:  portCfg_nxt  = regWrData;
        `ACOF_ADDR_CLK_DIV:   divider_select_pin_nxt   = {4'h0, regWrData[3:0]};
        `ACOF_ADDR_FORMAT:    format_nxt   = regWrData[1:0];
        `ACOF_ADDR_DLL:       dll_nxt      = regWrData[0];
        `ACOF_ADDR_POWER:     power_nxt    = regWrData[2:0];
        `ACOF_ADDR_SYNC_ROLE: syncRole_nxt = regWrData[0];
        default: ;
      endcase
    end
    rdData_nxt = 8'h00;
    if (regRd && (spiEnabled_r || regAddr == `ACOF_ADDR_CAL_STATUS)) begin
      case (regAddr)
        `ACOF_ADDR_PORT_CFG:   rdData_nxt = portCfg_r | {2'h0, softReset_r, 5'h00};
        `ACOF_ADDR_CLK_DIV:    rdData_nxt = divider_select_pin_r;
        `ACOF_ADDR_FORMAT:     rdData_nxt = {6'h00, format_r};
        `ACOF_ADDR_DLL:        rdData_nxt = {7'h00, dll_r};
        `ACOF_ADDR_POWER:      rdData_nxt = {5'h00, power_r};
        `ACOF_ADDR_SYNC_ROLE:  rdData_nxt = {7'h00, syncRole_r};
        `ACOF_ADDR_CAL_STATUS: rdData_nxt = {7'h00, calDone};
        default:               rdData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      portCfg_r    <= `ACOF_PORT_CFG_RST;
      divider_select_pin_r     <= `ACOF_CLK_DIV_RST;
      format_r     <= `ACOF_FORMAT_RST;
      dll_r        <= `ACOF_DLL_RST;
      power_r      <= `ACOF_POWER_RST;
      syncRole_r   <= `ACOF_SYNC_ROLE_RST;
      softReset_r  <= 1'b0;
      rdData_r     <= 8'h00;
      spiEnabled_r <= 1'b0;
      settle_r     <= 2'h0;
    end else begin
      portCfg_r    <= portCfg_nxt;
      divider_select_pin_r     <= divider_select_pin_nxt;
      format_r     <= format_nxt;
      dll_r        <= dll_nxt;
      power_r      <= power_nxt;
      syncRole_r   <= syncRole_nxt;
      softReset_r  <= softReset_nxt;
      rdData_r     <= rdData_nxt;
      spiEnabled_r <= spiEnabled_nxt;
      settle_r     <= settle_nxt;
    end
  end

  // ==========================================
  // Calibration sequencer
  acof_pkg::acof_cal_t calState_r, calState_nxt;
  logic [6:0] calCnt_r, calCnt_nxt;
  logic       calBusy_r, calBusy_nxt;

  assign calDone   = (calState_r == acof_pkg::CAL_DONE);
  assign calFinish = (calState_r == acof_pkg::CAL_RUN) && !softWr && recalN
                     && (calCnt_r == 7'(`ACOF_CAL_CYCLES - 1));

  always_comb begin
    calState_nxt = calState_r;
    calCnt_nxt   = calCnt_r;
    case (calState_r)
      acof_pkg::CAL_HOLD: begin
        calCnt_nxt = 7'h00;
        if (recalN) begin
          calState_nxt = acof_pkg::CAL_RUN;
        end
      end
      acof_pkg::CAL_RUN: begin
        calCnt_nxt = calCnt_r + 7'h01;
        if (calFinish) begin
          calState_nxt = acof_pkg::CAL_DONE;
        end
      end
      acof_pkg::CAL_DONE: calCnt_nxt = 7'h00;
      default: calState_nxt = acof_pkg::CAL_HOLD;
    endcase
    if (softWr) begin
      calState_nxt = acof_pkg::CAL_RUN;
      calCnt_nxt   = 7'h00;
    end
    if (!recalN) begin
      calState_nxt = acof_pkg::CAL_HOLD;
      calCnt_nxt   = 7'h00;
    end
    calBusy_nxt = (calState_nxt != acof_pkg::CAL_DONE);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      calState_r <= acof_pkg::CAL_RUN;
      calCnt_r   <= 7'h00;
      calBusy_r  <= 1'b1;
    end else begin
      calState_r <= calState_nxt;
      calCnt_r   <= calCnt_nxt;
      calBusy_r  <= calBusy_nxt;
    end
  end

  // ==========================================
  // Clock divider, phase select and sync role
  logic [1:0] ratio;
  logic [1:0] divMask;
  logic [1:0] divCnt_r, divCnt_nxt;
  logic       divReset;

  always_comb begin
    ratio = divider_select_pin_r[1:0];
    if (ratio == `ACOF_DIV_PIN) begin
      case (divStrap)
        `ACOF_STRAP_FLOAT: ratio = `ACOF_DIV_1;
        `ACOF_STRAP_HIGH:  ratio = `ACOF_DIV_4;
        default:           ratio = `ACOF_DIV_2;
      endcase
    end
    case (ratio)
      `ACOF_DIV_2: divMask = 2'h1;
      `ACOF_DIV_4: divMask = 2'h3;
      default:     divMask = 2'h0;
    endcase
  end

  assign divReset   = syncRole_r & syncAsserted;
  assign divCnt_nxt = divReset ? 2'h0 : (divCnt_r + 2'h1) & divMask;

  // ==========================================
  // Output stage
  logic [15:0] fmtWord;
  logic        strobe_r, strobe_nxt;
  logic [15:0] word_r, word_nxt;
  logic        valid_r, valid_nxt;
  logic        syncN_r, syncN_nxt;
  logic [1:0]  pwr_r, pwr_nxt;

  acof_fmt u_fmt (
    .offsetWord (coreSample),
    .format     (format_r),
    .overHigh   (coreOverHigh),
    .overLow    (coreOverLow),
    .outWord    (fmtWord)
  );

  always_comb begin
    strobe_nxt = !divReset && ((divCnt_r & divMask) == (divider_select_pin_r[3:2] & divMask));
    valid_nxt  = coreValid & calDone;
    word_nxt   = coreValid & calDone ? fmtWord : word_r;
    syncN_nxt  = syncRole_r ? 1'b1 : ~syncAsserted;
    pwr_nxt    = `ACOF_PWR_NORMAL;
    if (calDone) begin
      pwr_nxt = power_r[2] ? power_r[1:0] : pwrStrap;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      divCnt_r <= 2'h0;
      strobe_r <= 1'b0;
      word_r   <= 16'h0000;
      valid_r  <= 1'b0;
      syncN_r  <= 1'b1;
      pwr_r    <= `ACOF_PWR_NORMAL;
    end else begin
      divCnt_r <= divCnt_nxt;
      strobe_r <= strobe_nxt;
      word_r   <= word_nxt;
      valid_r  <= valid_nxt;
      syncN_r  <= syncN_nxt;
      pwr_r    <= pwr_nxt;
    end
  end

  assign regRdData        = rdData_r;
  assign sampleStrobe     = strobe_r;
  assign sampleWord       = word_r;
  assign sampleValid      = valid_r;
  assign linkSyncRequestN = syncN_r;
  assign calRunning       = calBusy_r;
  assign powerState       = pwr_r;
  assign dllRangeSlow     = dll_r;

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_recal_holds: assert property (!recalN |=> !calDone) else $error("recal did not hold");
  a_clamp_high: assert property (coreValid && calDone && coreOverHigh |=> sampleWord == 16'hFFFF)
    else $error("over-range not clamped high");
  a_div_four: assert property ((divMask == 2'h3 && $stable(divMask) && !divReset
    && $stable(divider_select_pin_r) && strobe_r) ##1 (divMask == 2'h3 && !divReset && $stable(divider_select_pin_r)) [*2]
    |=> !strobe_r && !$past(strobe_r) && !$past(strobe_r, 2))
    else $error("divide by four spacing wrong");
  a_sync_default: assert property (!syncRole_r |=> syncN_r == !$past(syncAsserted))
    else $error("sync not passed to link");
  a_soft_restart: assert property (softWr |=> !calDone && softReset_r)
    else $error("soft reset did not restart");
  a_soft_clears: assert property (calFinish |=> !softReset_r && calDone)
    else $error("soft reset did not clear");
  a_port_locked: assert property (!spiEnabled_r && regWr && regAddr == `ACOF_ADDR_FORMAT
    |=> $stable(format_r)) else $error("write taken while port disabled");
  a_twos_msb: assert property (coreValid && calDone && format_r == `ACOF_FMT_TWOS
    && !coreOverHigh && !coreOverLow |=> sampleWord == {~$past(coreSample[15]),
    $past(coreSample[14:0])}) else $error("two's complement wrong");
  a_cal_status: assert property (regRd && regAddr == `ACOF_ADDR_CAL_STATUS
    |=> regRdData == {7'h00, $past(calDone)}) else $error("cal status wrong");
  a_pwr_override: assert property (calDone && power_r[2] |=> powerState == $past(power_r[1:0]))
    else $error("power override ignored");

  c_cal_done:   cover property (calFinish);
  c_soft_reset: cover property (softWr);
  c_div_reset:  cover property (divReset);
  c_gray_out:   cover property (valid_r && format_r == `ACOF_FMT_GRAY);
endmodule // acof_top
`default_nettype wire

/* File: verification/acof_link_rx.sv */
// Link receiver model: drives the sync pair and keeps the last sample word
`default_nettype none
module acof_link_rx (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        wantSync,
  input  wire logic        sampleValid,
  input  wire logic [15:0] sampleWord,
  output logic             sync_pair_pos,
  output logic             sync_pair_neg,
  output logic      [15:0] lastWord_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Sync request: pos low and neg high asks for lane realignment
  assign sync_pair_pos = ~wantSync;
  assign sync_pair_neg = wantSync;
  // ==========================================
  // Word capture
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lastWord_r <= 16'h0000;
    end else if (sampleValid) begin
      lastWord_r <= sampleWord;
    end
  end
endmodule // acof_link_rx
`default_nettype wire

/* File: verification/test_adc_control_and_output_format.sv */
// Self-checking bench for the converter control and output format block
`default_nettype none
`include "acof_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_adc_control_and_output_format;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWrData = 8'h00;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        recal_request_n = 1'b1;
  logic [1:0]  divider_select_pin = 2'h1;
  logic [1:0]  power_state_pin = 2'h0;
  logic [15:0] coreSample = 16'h0000;
  logic        coreValid = 1'b0;
  logic        coreOverHigh = 1'b0;
  logic        coreOverLow = 1'b0;
  logic        wantSync = 1'b0;
  logic [7:0]  regRdData;
  logic [15:0] sampleWord, lastWord;
  logic        sampleStrobe, sampleValid, linkSyncRequestN, calRunning, dllRangeSlow;
  logic        sync_pair_pos, sync_pair_neg;
  logic [1:0]  powerState;
  int          fails, comparisons, firstHit;

  always #4 clk_sys = ~clk_sys;

  acof_top i_dut (.clk_sys, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .recal_request_n, .divider_select_pin, .power_state_pin, .sync_pair_pos, .sync_pair_neg,
    .coreSample, .coreValid, .coreOverHigh, .coreOverLow, .sampleStrobe, .sampleWord,
    .sampleValid, .linkSyncRequestN, .calRunning, .powerState, .dllRangeSlow);

  acof_link_rx i_rx (.clk_sys, .rst, .wantSync, .sampleValid, .sampleWord, .sync_pair_pos,
    .sync_pair_neg, .lastWord_r(lastWord));

  // ==========================================
  // Bus and stream tasks
  task automatic results();
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    `CHK(regRdData, e)
  endtask

  task automatic smpChk(input logic [15:0] s, input logic hi, input logic lo,
                        input logic [15:0] e);
    @(posedge clk_sys);
    coreSample <= s;
    coreOverHigh <= hi;
    coreOverLow <= lo;
    coreValid <= 1'b1;
    @(posedge clk_sys);
    coreValid <= 1'b0;
    coreOverHigh <= 1'b0;
    coreOverLow <= 1'b0;
    #1;
    `CHK(sampleValid, 1'b1)
    `CHK(sampleWord, e)
  endtask

  // Bounded wait for calibration end; n returns the cycles spent
  task automatic waitCal(input int lim, output int n);
    n = 0;
    while (calRunning !== 1'b0 && n < lim) begin
      cyc(1);
      n++;
    end
    if (calRunning !== 1'b0) begin
      fails++;
      results();
    end
  endtask

  // Strobes in 16 cycles; spans 26 edges with a pin change so phases line up
  task automatic strobes(input logic [1:0] pin, input int e);
    int c;
    c = 0;
    firstHit = -1;
    @(posedge clk_sys);
    divider_select_pin <= pin;
    repeat (9) @(posedge clk_sys);
    for (int i = 0; i < 16; i++) begin
      cyc(1);
      if (sampleStrobe === 1'b1 && firstHit < 0) firstHit = i;
      c += int'(sampleStrobe === 1'b1);
    end
    `CHK(c, e)
  endtask

  // ==========================================
  // Scenarios
  task automatic testFormat();
    logic [15:0] v [5] = '{16'h0000, 16'h0001, 16'h8000, 16'hFFFE, 16'hFFFF};
    smpChk(16'h8000, 1'b0, 1'b0, 16'h0000);
    for (int f = 0; f < 3; f++) begin
      wrReg(`ACOF_ADDR_FORMAT, 8'(f));
      rdChk(`ACOF_ADDR_FORMAT, 8'(f));
      for (int i = 0; i < 5; i++) begin
        smpChk(v[i], 1'b0, 1'b0, f == 0 ? v[i] : f == 1 ? v[i] ^ 16'h8000 : v[i] ^ (v[i] >> 1));
      end
      smpChk(16'h1234, 1'b1, 1'b0, 16'hFFFF);
      smpChk(16'h1234, 1'b0, 1'b1, 16'h0000);
    end
    smpChk(16'hFFFF, 1'b0, 1'b0, 16'h8000);
    cyc(1);
    `CHK(lastWord, 16'h8000)
    wrReg(`ACOF_ADDR_FORMAT, 8'h01);
  endtask

  task automatic testDivider();
    int p0;
    strobes(`ACOF_STRAP_HIGH, 4);
    strobes(`ACOF_STRAP_FLOAT, 16);
    strobes(`ACOF_STRAP_LOW, 8);
    wrReg(`ACOF_ADDR_CLK_DIV, 8'h02);
    strobes(`ACOF_STRAP_HIGH, 8);
    wrReg(`ACOF_ADDR_CLK_DIV, 8'h03);
    strobes(`ACOF_STRAP_HIGH, 4);
    p0 = firstHit;
    wrReg(`ACOF_ADDR_CLK_DIV, 8'h07);
    strobes(`ACOF_STRAP_HIGH, 4);
    `CHK(firstHit != p0, 1'b1)
    wrReg(`ACOF_ADDR_CLK_DIV, 8'h01);
    strobes(`ACOF_STRAP_HIGH, 16);
  endtask

  task automatic testSync();
    @(posedge clk_sys);
    wantSync <= 1'b1;
    cyc(5);
    `CHK(linkSyncRequestN, 1'b0)
    @(posedge clk_sys);
    wantSync <= 1'b0;
    cyc(5);
    `CHK(linkSyncRequestN, 1'b1)
    wrReg(`ACOF_ADDR_SYNC_ROLE, 8'h01);
    rdChk(`ACOF_ADDR_SYNC_ROLE, 8'h01);
    @(posedge clk_sys);
    wantSync <= 1'b1;
    strobes(`ACOF_STRAP_HIGH, 0);
    `CHK(linkSyncRequestN, 1'b1)
    @(posedge clk_sys);
    wantSync <= 1'b0;
    wrReg(`ACOF_ADDR_SYNC_ROLE, 8'h00);
  endtask

  task automatic testResets();
    int n;
    wrReg(`ACOF_ADDR_FORMAT, 8'h02);
    wrReg(`ACOF_ADDR_PORT_CFG, 8'h20);
    #1;
    `CHK(calRunning, 1'b1)
    rdChk(`ACOF_ADDR_PORT_CFG, 8'h20);
    waitCal(80, n);
    `CHK(n inside {[58:64]}, 1'b1)
    rdChk(`ACOF_ADDR_PORT_CFG, 8'h00);
    rdChk(`ACOF_ADDR_FORMAT, 8'h01);
    rdChk(`ACOF_ADDR_CAL_STATUS, 8'h01);
    @(posedge clk_sys);
    recal_request_n <= 1'b0;
    @(posedge clk_sys);
    recal_request_n <= 1'b1;
    cyc(4);
    `CHK(calRunning, 1'b1)
    rdChk(`ACOF_ADDR_CAL_STATUS, 8'h00);
    waitCal(80, n);
    rdChk(`ACOF_ADDR_CAL_STATUS, 8'h01);
  endtask

  task automatic testRegs();
    `CHK(dllRangeSlow, 1'b0)
    wrReg(`ACOF_ADDR_DLL, 8'h01);
    cyc(2);
    `CHK(dllRangeSlow, 1'b1)
    rdChk(`ACOF_ADDR_DLL, 8'h01);
    rdChk(8'h55, 8'h00);
    wrReg(`ACOF_ADDR_POWER, 8'h06);
    cyc(3);
    `CHK(powerState, 2'h2)
    wrReg(`ACOF_ADDR_POWER, 8'h00);
    cyc(3);
    `CHK(powerState, 2'h0)
  endtask

  task automatic testStrap();
    int n;
    @(posedge clk_sys);
    power_state_pin <= `ACOF_STRAP_FLOAT;
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    waitCal(100, n);
    cyc(6);
    `CHK(powerState, 2'h1)
    wrReg(`ACOF_ADDR_FORMAT, 8'h00);
    @(posedge clk_sys);
    power_state_pin <= `ACOF_STRAP_LOW;
    cyc(10);
    `CHK(powerState, 2'h0)
    rdChk(`ACOF_ADDR_FORMAT, 8'h01);
    wrReg(`ACOF_ADDR_FORMAT, 8'h00);
    rdChk(`ACOF_ADDR_FORMAT, 8'h00);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    int n;
    fails = 0;
    comparisons = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rdChk(`ACOF_ADDR_CAL_STATUS, 8'h00);
    waitCal(100, n);
    `CHK(powerState, 2'h0)
    testFormat();
    testDivider();
    testSync();
    testResets();
    testRegs();
    testStrap();
    results();
  end
endmodule // test_adc_control_and_output_format
`default_nettype wire
